// ==== lmo_consts.svh ====
/*
 * Constants of the logical micro-op unit: register offsets, microword fields,
 * opcode codes, reset values and cycle counts.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef LMO_CONSTS_SVH
`define LMO_CONSTS_SVH

// ****************************************************************
// Register map (byte addresses on the APB side)
// ****************************************************************
`define LMO_OFS_MI        8'h00
`define LMO_OFS_STATE     8'h04
`define LMO_OFS_RF_BASE   2'b01
`define LMO_ADDR_RF_MSB   7
`define LMO_ADDR_RF_LSB   6
`define LMO_ADDR_IX_MSB   5
`define LMO_ADDR_IX_LSB   2

// ****************************************************************
// State register fields
// ****************************************************************
`define LMO_ST_BUSY_BIT   8
`define LMO_ST_STAT_MSB   7
`define LMO_ST_STAT_LSB   4
`define LMO_ST_CC_MSB     3
`define LMO_ST_CC_LSB     0

// ****************************************************************
// Microinstruction fields
// ****************************************************************
`define LMO_OPC_MSB       15
`define LMO_OPC_LSB       9
`define LMO_FLAG_BIT      8
`define LMO_SRC_MSB       7
`define LMO_SRC_LSB       4
`define LMO_DST_MSB       3
`define LMO_DST_LSB       0

// ****************************************************************
// Opcode codes in microword bits 15..9
// ****************************************************************
`define LMO_OPC_ANDN_W    7'h69
`define LMO_OPC_OR_B      7'h64
`define LMO_OPC_OR_W      7'h65
`define LMO_OPC_XOR_B     7'h66
`define LMO_OPC_XOR_W     7'h67
`define LMO_OPC_INV_B     7'h4E

// ****************************************************************
// Reset values and microcycle counts
// ****************************************************************
`define LMO_RST_MI        16'h0000
`define LMO_RST_BYTE      8'h00
`define LMO_RST_FLAGS     4'h0
`define LMO_BYTE_CYCLES   1
`define LMO_WORD_CYCLES   2

`endif

// ==== lmo_eval_if.sv ====
/*
 * Carrier between the sequencing top and the logic evaluator.
 * Assumes lmo_pkg is compiled first; purely combinational signals.
 */
`timescale 1ns/1ns
`default_nettype none

interface lmo_eval_if;
    import lmo_pkg::*;

    lmo_op_type     op;
    logic           flagged;
    logic [15:0]    dst_word;
    logic [15:0]    src_word;
    lmo_status_type status_in;
    lmo_cc_type     cc_in;
    logic [15:0]    result;
    lmo_status_type status_out;
    lmo_cc_type     cc_out;

    modport evaluator (
        input  op,
        input  flagged,
        input  dst_word,
        input  src_word,
        input  status_in,
        input  cc_in,
        output result,
        output status_out,
        output cc_out
    );

    modport sequencer (
        output op,
        output flagged,
        output dst_word,
        output src_word,
        output status_in,
        output cc_in,
        input  result,
        input  status_out,
        input  cc_out
    );
endinterface

`default_nettype wire

// ==== lmo_logic_eval.sv ====
/*
 * Combinational evaluator: result, internal status flags and condition codes
 * of one logical microinstruction.
 * Assumes the caller registers the outputs at the writeback microcycle.
 */
`timescale 1ns/1ns
`default_nettype none

module lmo_logic_eval
    import lmo_pkg::*;
(
    lmo_eval_if.evaluator ev
);

    logic [15:0] res;
    logic        is_word;
    logic        neg;
    logic        zero;

    // ****************************************************************
    // Result
    // ****************************************************************
    // Byte results leave the upper byte zero; the top never stores it
    always_comb begin
        res = ev.dst_word;
        case (ev.op)
            LMO_AND_NOT_WORD: res = ev.dst_word & ~ev.src_word;
            LMO_OR_BYTE:      res = {8'h00, ev.dst_word[7:0] | ev.src_word[7:0]};
            LMO_OR_WORD:      res = ev.dst_word | ev.src_word;
            LMO_XOR_BYTE:     res = {8'h00, ev.dst_word[7:0] ^ ev.src_word[7:0]};
            LMO_XOR_WORD:     res = ev.dst_word ^ ev.src_word;
            LMO_INVERT_BYTE:  res = {8'h00, ~ev.src_word[7:0]};
            default:          res = ev.dst_word;
        endcase
    end

    // ****************************************************************
    // Flags
    // ****************************************************************
    // Sign and zero judged at the width of the operation
    always_comb begin
        is_word = lmo_is_word(ev.op);
        neg     = is_word ? res[15] : res[7];
        zero    = is_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
        ev.result     = res;
        ev.status_out = ev.status_in;
        ev.cc_out     = ev.cc_in;
        if (ev.op != LMO_NONE) begin
            ev.status_out.negative_status_flag = neg;
            ev.status_out.zero_status_flag     = zero;
            if (ev.flagged) begin
                ev.cc_out.n = neg;
                ev.cc_out.z = zero;
                if (ev.op == LMO_INVERT_BYTE) begin
                    ev.cc_out.c = 1'b0;
                end else begin
                    ev.cc_out.v = 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== lmo_logical_micro_op_unit.sv ====
/*
 * Logical micro-op unit: sixteen byte registers, internal status flags and
 * condition codes, executing the logical microinstructions issued over APB.
 * Assumes a single pclk domain and an APB master that keeps the protocol.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lmo_consts.svh"

module lmo_logical_micro_op_unit
    import lmo_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0]     regs      [16];
    logic [7:0]     next_regs [16];
    logic [15:0]    mi;
    logic [15:0]    next_mi;
    lmo_state_type  state;
    lmo_state_type  next_state;
    lmo_status_type status;
    lmo_status_type next_status;
    lmo_cc_type     cc;
    lmo_cc_type     next_cc;
    logic [31:0]    next_prdata;

    logic           access;
    logic           is_mi;
    logic           is_state;
    logic           is_rf;
    logic [3:0]     rf_ix;
    logic           busy;
    logic           issue;
    logic           wb;
    lmo_op_type     op_q;
    logic [3:0]     src_ix;
    logic [3:0]     dst_ix;
    logic [3:0]     src_hi;
    logic [3:0]     dst_hi;

    lmo_eval_if ev ();

    lmo_logic_eval u_eval (
        .ev (ev)
    );

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Zero-wait slave: read data is caught in the setup cycle
    assign access   = psel && penable;
    assign is_mi    = (paddr == ADDR_W'(`LMO_OFS_MI));
    assign is_state = (paddr == ADDR_W'(`LMO_OFS_STATE));
    assign is_rf    = (paddr[`LMO_ADDR_RF_MSB:`LMO_ADDR_RF_LSB] == `LMO_OFS_RF_BASE)
                      && (paddr[1:0] == 2'b00)
                      && ((paddr >> (`LMO_ADDR_RF_MSB + 1)) == '0);
    assign rf_ix    = paddr[`LMO_ADDR_IX_MSB:`LMO_ADDR_IX_LSB];
    assign busy     = (state != LMO_IDLE);
    assign pready   = 1'b1;

    // Writes while busy are refused so operands cannot shift mid-operation
    always_comb begin
        pslverr = 1'b0;
        if (access) begin
            if (!(is_mi || is_state || is_rf)) begin
                pslverr = 1'b1;
            end else if (pwrite && busy) begin
                pslverr = 1'b1;
            end else if (pwrite && is_mi && (lmo_decode(pwdata[15:0]) == LMO_NONE)) begin
                pslverr = 1'b1;
            end
        end
    end

    assign issue = access && pwrite && is_mi && !pslverr;

    // ****************************************************************
    // Microword fields
    // ****************************************************************
    assign op_q   = lmo_decode(mi);
    assign src_ix = mi[`LMO_SRC_MSB:`LMO_SRC_LSB];
    assign dst_ix = mi[`LMO_DST_MSB:`LMO_DST_LSB];
    assign src_hi = src_ix + 4'h1;
    assign dst_hi = dst_ix + 4'h1;

    // Operands to the evaluator; upper byte unused by byte operations
    assign ev.op        = busy ? op_q : LMO_NONE;
    assign ev.flagged   = mi[`LMO_FLAG_BIT];
    assign ev.dst_word  = {regs[dst_hi], regs[dst_ix]};
    assign ev.src_word  = {regs[src_hi], regs[src_ix]};
    assign ev.status_in = status;
    assign ev.cc_in     = cc;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Byte ops write back in CYC1, word ops hold one more microcycle
    always_comb begin
        next_state = state;
        next_mi    = mi;
        wb         = 1'b0;
        case (state)
            LMO_IDLE: begin
                if (issue) begin
                    next_mi    = pwdata[15:0];
                    next_state = LMO_CYC1;
                end
            end
            LMO_CYC1: begin
                if (lmo_is_word(op_q)) begin
                    next_state = LMO_CYC2;
                end else begin
                    wb         = 1'b1;
                    next_state = LMO_IDLE;
                end
            end
            LMO_CYC2: begin
                wb         = 1'b1;
                next_state = LMO_IDLE;
            end
            default: begin
                next_state = LMO_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Register file and flags
    // ****************************************************************
    // Only the destination byte or pair is written; a source that does not overlap it stays put
    always_comb begin
        next_regs   = regs;
        next_status = status;
        next_cc     = cc;
        if (wb) begin
            next_regs[dst_ix] = ev.result[7:0];
            if (lmo_is_word(op_q)) begin
                next_regs[dst_hi] = ev.result[15:8];
            end
            next_status = ev.status_out;
            next_cc     = ev.cc_out;
        end else if (access && pwrite && !pslverr) begin
            if (is_rf) begin
                next_regs[rf_ix] = pwdata[7:0];
            end else if (is_state) begin
                next_status = pwdata[`LMO_ST_STAT_MSB:`LMO_ST_STAT_LSB];
                next_cc     = pwdata[`LMO_ST_CC_MSB:`LMO_ST_CC_LSB];
            end
        end
    end

    // Read data captured in setup so prdata comes from a flip-flop
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h00000000;
            if (is_mi) begin
                next_prdata[15:0] = mi;
            end else if (is_state) begin
                next_prdata[`LMO_ST_BUSY_BIT] = busy;
                next_prdata[`LMO_ST_STAT_MSB:`LMO_ST_STAT_LSB] = status;
                next_prdata[`LMO_ST_CC_MSB:`LMO_ST_CC_LSB] = cc;
            end else if (is_rf) begin
                next_prdata[7:0] = regs[rf_ix];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= LMO_IDLE;
            mi     <= `LMO_RST_MI;
            status <= `LMO_RST_FLAGS;
            cc     <= `LMO_RST_FLAGS;
            prdata <= 32'h00000000;
            for (int i = 0; i < 16; i++) begin
                regs[i] <= `LMO_RST_BYTE;
            end
        end else begin
            state  <= next_state;
            mi     <= next_mi;
            status <= next_status;
            cc     <= next_cc;
            prdata <= next_prdata;
            regs   <= next_regs;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Reference values from the registers, independent of the evaluator
    logic [7:0]  src_snap;
    logic        overlap;
    logic [7:0]  or_byte_ref;
    logic [7:0]  xor_byte_ref;
    logic [15:0] dst_pair;
    logic [15:0] src_pair;
    logic [15:0] andn_word_ref;
    logic [15:0] or_word_ref;
    logic [15:0] xor_word_ref;
    logic        res_sign;
    logic        res_zero;
    assign src_snap      = regs[src_ix];
    assign overlap       = (src_ix == dst_ix) || (lmo_is_word(op_q) && (src_ix == dst_hi));
    assign or_byte_ref   = regs[dst_ix] | regs[src_ix];
    assign xor_byte_ref  = regs[dst_ix] ^ regs[src_ix];
    assign dst_pair      = {regs[dst_hi], regs[dst_ix]};
    assign src_pair      = {regs[src_hi], regs[src_ix]};
    assign andn_word_ref = dst_pair & ~src_pair;
    assign or_word_ref   = dst_pair | src_pair;
    assign xor_word_ref  = dst_pair ^ src_pair;
    // Sign and zero read back from the stored destination after writeback
    assign res_sign      = lmo_is_word(op_q) ? regs[dst_hi][7] : regs[dst_ix][7];
    assign res_zero      = lmo_is_word(op_q) ? (dst_pair == 16'h0000) : (regs[dst_ix] == 8'h00);

    sequence issue_word_s;
        issue && lmo_is_word(lmo_decode(pwdata[15:0]));
    endsequence
    sequence issue_byte_s;
        issue && !lmo_is_word(lmo_decode(pwdata[15:0]));
    endsequence
    sequence word_run_s;
        (state == LMO_CYC1) ##1 (state == LMO_CYC2) ##1 (state == LMO_IDLE);
    endsequence

    word_two_cyc_a: assert property (issue_word_s |=> word_run_s)
        else $error("word operation did not take two microcycles");
    byte_one_cyc_a: assert property (issue_byte_s |=> (state == LMO_CYC1) ##1 !busy)
        else $error("byte operation did not take one microcycle");
    src_kept_a: assert property (wb && !overlap |=> src_snap == $past(src_snap))
        else $error("source register changed by a logical operation");
    neg_flag_a: assert property (wb |=> status.negative_status_flag == res_sign)
        else $error("negative status flag does not match result");
    zero_flag_a: assert property (wb |=> status.zero_status_flag == res_zero)
        else $error("zero status flag does not match result");
    carry_kept_a: assert property (wb |=> status[1:0] == $past(status[1:0]))
        else $error("half-carry or carry-out status flag changed");
    cc_unflag_a: assert property (wb && !mi[`LMO_FLAG_BIT] |=> cc == $past(cc))
        else $error("condition codes changed by unflagged operation");
    v_clear_a: assert property (wb && mi[`LMO_FLAG_BIT] && op_q != LMO_INVERT_BYTE
        |=> !cc.v && (cc.c == $past(cc.c)))
        else $error("flagged logical op did not clear V or altered C");
    inv_c_clear_a: assert property (wb && mi[`LMO_FLAG_BIT] && op_q == LMO_INVERT_BYTE
        |=> !cc.c && (cc.v == $past(cc.v)))
        else $error("flagged invert did not clear C or altered V");
    or_byte_res_a: assert property (wb && op_q == LMO_OR_BYTE
        |=> regs[dst_ix] == $past(or_byte_ref))
        else $error("OR byte result wrong");
    cc_nz_a: assert property (wb && mi[`LMO_FLAG_BIT]
        |=> (cc.n == res_sign) && (cc.z == res_zero))
        else $error("flagged op did not set N and Z from the result");
    xor_c_kept_a: assert property (wb && mi[`LMO_FLAG_BIT] && op_q == LMO_XOR_BYTE
        |=> cc.c == $past(cc.c))
        else $error("flagged exclusive-OR byte altered C");
    andn_res_a: assert property (wb && op_q == LMO_AND_NOT_WORD
        |=> dst_pair == $past(andn_word_ref))
        else $error("and-complement word result wrong");
    or_word_res_a: assert property (wb && op_q == LMO_OR_WORD
        |=> dst_pair == $past(or_word_ref))
        else $error("OR word result wrong");
    xor_byte_res_a: assert property (wb && op_q == LMO_XOR_BYTE
        |=> regs[dst_ix] == $past(xor_byte_ref))
        else $error("exclusive-OR byte result wrong");
    xor_word_res_a: assert property (wb && op_q == LMO_XOR_WORD
        |=> dst_pair == $past(xor_word_ref))
        else $error("exclusive-OR word result wrong");
    inv_res_a: assert property (wb && op_q == LMO_INVERT_BYTE
        |=> regs[dst_ix] == ~$past(src_snap))
        else $error("invert byte result wrong");

endmodule

`default_nettype wire

// ==== lmo_pkg.sv ====
/*
 * Types and the opcode decoder of the logical micro-op unit.
 * Assumes lmo_consts.svh is on the include path.
 */
`include "lmo_consts.svh"

package lmo_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        LMO_NONE,
        LMO_AND_NOT_WORD,
        LMO_OR_BYTE,
        LMO_OR_WORD,
        LMO_XOR_BYTE,
        LMO_XOR_WORD,
        LMO_INVERT_BYTE
    } lmo_op_type;

    typedef enum logic [1:0] {
        LMO_IDLE,
        LMO_CYC1,
        LMO_CYC2
    } lmo_state_type;

    typedef struct packed {
        logic negative_status_flag;
        logic zero_status_flag;
        logic half_carry_status_flag;
        logic carry_out_status_flag;
    } lmo_status_type;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } lmo_cc_type;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    // Opcode field to operation; anything else is not this unit's
    function automatic lmo_op_type lmo_decode(input logic [15:0] mi);
        lmo_op_type op;
        op = LMO_NONE;
        case (mi[`LMO_OPC_MSB:`LMO_OPC_LSB])
            `LMO_OPC_ANDN_W: op = LMO_AND_NOT_WORD;
            `LMO_OPC_OR_B:   op = LMO_OR_BYTE;
            `LMO_OPC_OR_W:   op = LMO_OR_WORD;
            `LMO_OPC_XOR_B:  op = LMO_XOR_BYTE;
            `LMO_OPC_XOR_W:  op = LMO_XOR_WORD;
            `LMO_OPC_INV_B:  op = LMO_INVERT_BYTE;
            default:         op = LMO_NONE;
        endcase
        return op;
    endfunction

    // Word operations work on register pairs and take two microcycles
    function automatic logic lmo_is_word(input lmo_op_type op);
        return (op == LMO_AND_NOT_WORD) || (op == LMO_OR_WORD) || (op == LMO_XOR_WORD);
    endfunction

endpackage

// ==== lmo_seq_model.sv ====
/*
 * Sequencer model: issues microwords and register accesses as an APB master.
 * Assumes the bench calls its tasks just after a rising pclk edge.
 */
`timescale 1ns/1ns
`default_nettype none

module lmo_seq_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Quiet bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // One transfer; left selected so another may follow without a gap
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
    endtask

    // Release; stale write data is scrambled so nothing relies on it
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~pwdata;
        @(posedge pclk);
    endtask
endmodule

`default_nettype wire

// ==== tb_top.sv ====
/*
 * Self-checking bench of the logical micro-op unit.
 * Assumes the register map and opcodes of lmo_consts.svh.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lmo_consts.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  opc_tab [6];
    int          n_mismatch;
    int          total_checks;

    lmo_logical_micro_op_unit #(.ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    lmo_seq_model i_seq (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] reg_addr(input logic [3:0] i);
        return {`LMO_OFS_RF_BASE, i, 2'b00};
    endfunction

    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] q;
        logic        err;
        i_seq.xfer(1'b1, a, d, q, err);
        i_seq.idle();
        `CHK("write error", exp_err, err)
    endtask

    task automatic apb_rd(input logic [7:0] a, output logic [31:0] q);
        logic err;
        i_seq.xfer(1'b0, a, 32'h0000_0000, q, err);
        i_seq.idle();
        `CHK("read error", 1'b0, err)
    endtask

    // Poll busy; the watchdog bounds a unit that never goes idle
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h0000_0100;
        while (s[`LMO_ST_BUSY_BIT] !== 1'b0) apb_rd(`LMO_OFS_STATE, s);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic check_reset();
        logic [31:0] q;
        apb_rd(`LMO_OFS_STATE, q);
        `CHK("state after reset", 32'h0000_0000, q)
        apb_rd(`LMO_OFS_MI, q);
        `CHK("microword after reset", 32'h0000_0000, q)
        apb_rd(reg_addr(4'hF), q);
        `CHK("register after reset", 32'h0000_0000, q)
        `CHK("ready level", 1'b1, pready)
        $display("test reset done");
    endtask

    // Operation k of the table; flags preset so kept bits are visible
    task automatic run_op(input int k, input logic fl, input logic [15:0] dv,
                          input logic [15:0] sv);
        logic [3:0]  a;
        logic [3:0]  b;
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] slo;
        logic [31:0] shi;
        logic [31:0] st;
        logic        word;
        logic        neg;
        logic        zero;
        logic [15:0] res;
        logic [3:0]  exp_cc;
        a = 4'(2 * k);
        b = a + 4'd6;
        word = (k == 0) || (k == 2) || (k == 4);
        apb_wr(reg_addr(a), {24'h0, dv[7:0]}, 1'b0);
        apb_wr(reg_addr(a + 4'd1), {24'h0, dv[15:8]}, 1'b0);
        apb_wr(reg_addr(b), {24'h0, sv[7:0]}, 1'b0);
        apb_wr(reg_addr(b + 4'd1), {24'h0, sv[15:8]}, 1'b0);
        apb_wr(`LMO_OFS_STATE, 32'h0000_0033, 1'b0);
        apb_wr(`LMO_OFS_MI, {16'h0, opc_tab[k], fl, b, a}, 1'b0);
        wait_idle();
        apb_rd(reg_addr(a), lo);
        apb_rd(reg_addr(a + 4'd1), hi);
        apb_rd(reg_addr(b), slo);
        apb_rd(reg_addr(b + 4'd1), shi);
        apb_rd(`LMO_OFS_STATE, st);
        case (k)
            0:       res = dv & ~sv;
            1, 2:    res = dv | sv;
            3, 4:    res = dv ^ sv;
            default: res = ~sv;
        endcase
        // Byte operations leave the upper register alone
        if (!word) res[15:8] = dv[15:8];
        neg = word ? res[15] : res[7];
        zero = word ? (res == 16'h0000) : (res[7:0] == 8'h00);
        exp_cc = fl ? {neg, zero, k == 5, k != 5} : 4'h3;
        `CHK("dest low", {24'h0, res[7:0]}, lo)
        `CHK("dest high", {24'h0, res[15:8]}, hi)
        `CHK("source pair", sv, {shi[7:0], slo[7:0]})
        `CHK("status", {neg, zero, 2'b11}, st[7:4])
        `CHK("cond codes", exp_cc, st[3:0])
        $display("test op %0d flagged %0d done", k, fl);
    endtask

    // Second issue lands while a word op is still in its second cycle
    task automatic back_to_back(input logic [15:0] mi, input logic exp_err);
        logic [31:0] q;
        logic        e1;
        logic        e2;
        i_seq.xfer(1'b1, `LMO_OFS_MI, {16'h0, mi}, q, e1);
        i_seq.xfer(1'b1, `LMO_OFS_MI, {16'h0, mi}, q, e2);
        i_seq.idle();
        wait_idle();
        `CHK("first issue error", 1'b0, e1)
        `CHK("second issue error", exp_err, e2)
        apb_rd(`LMO_OFS_MI, q);
        `CHK("last microword", {16'h0, mi}, q)
        $display("test back-to-back done");
    endtask

    task automatic refusals();
        logic [31:0] q;
        apb_wr(8'h08, 32'h0000_00FF, 1'b1);
        apb_wr(`LMO_OFS_MI, 32'h0000_0000, 1'b1);
        apb_rd(`LMO_OFS_MI, q);
        `CHK("microword kept", {16'h0, `LMO_OPC_OR_B, 9'h042}, q)
        $display("test refusals done");
    endtask

    // ****************************************************************
    // Run control
    // ****************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Far above the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        results();
    end

    initial begin
        n_mismatch = 0;
        total_checks = 0;
        opc_tab = '{`LMO_OPC_ANDN_W, `LMO_OPC_OR_B, `LMO_OPC_OR_W,
                    `LMO_OPC_XOR_B, `LMO_OPC_XOR_W, `LMO_OPC_INV_B};
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_reset();
        for (int k = 0; k < 6; k++) begin
            for (int f = 0; f < 2; f++) begin
                run_op(k, f[0], 16'h80F0, 16'h0F0F);
                run_op(k, f[0], 16'h1234, 16'h1234);
            end
        end
        back_to_back({`LMO_OPC_ANDN_W, 9'h042}, 1'b1);
        back_to_back({`LMO_OPC_OR_B, 9'h042}, 1'b0);
        refusals();
        results();
    end
endmodule

`default_nettype wire
